// [verilog/bmam_map.sv]
// Banked program and data memory address map of the core
//
// How it works
// - Thirteen bit counter over 8K x 14 space
// - Only low ten fetch bits decode; wraps
// - Fetch starts at 0000h after reset
// - Interrupt loads counter with 0004h
// - Data memory split into two banks
// - Lowest 32 addresses per bank are specials
// - 20h-5Fh reach shared RAM in both banks
// - Unimplemented reads zero, writes ignored
// - Flag bit 5 selects the bank
// - 64 bytes, direct or indirect reach
// - Location 00h/80h redirects through pointer
// - Bank one maps 80h-FFh, zero 00h-7Fh
`timescale 1ns/100ps
module bmam_map
  import bmam_pkg::*;
(
  input  wire logic                  clk_sys,   // System clock, 50 MHz
  input  wire logic                  arst_n,    // Async reset, active low
  input  wire bmam_bus_type          bus,       // Operand access from core
  input  wire bmam_pc_ctl_type       pc_ctl,    // Counter control
  output logic      [DATA_WIDTH-1:0] rdata,     // Read data, next cycle
  output logic      [PC_WIDTH-1:0]   pc,        // Full program counter
  output logic      [PROG_WIDTH-1:0] fetch_addr,// Decoded fetch address
  output logic                       bank_sel,  // Current bank select
  output logic      [7:0]            data_addr  // Last resolved address
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]             flags;       // Core flags and bank bits
  logic [7:0]             pointer;     // Indirect pointer
  logic [LATCH_WIDTH-1:0] latch;       // Upper program counter latch
  logic [PC_WIDTH-1:0]    next_pc;
  logic [7:0]             next_flags;
  logic [DATA_WIDTH-1:0]  next_rdata;

  // ****************************************************************
  // Address formation
  // ****************************************************************

  // Direct access at in-bank offset zero goes through the pointer
  wire       is_indirect = (bus.addr == OFS_INDIRECT_ACCESS_PORT);
  // Bank bit sits above the opcode's seven bits
  wire [7:0] direct_addr = {flags[BIT_BANK_SELECT], bus.addr};
  // Pointer supplies all eight bits, bank bit unused
  wire [7:0] full_addr   = is_indirect ? pointer : direct_addr;
  // Both banks share one in-bank offset space
  wire [6:0] bank_ofs    = full_addr[6:0];
  // Pointer aimed back at the indirect slot reaches nothing
  wire       self_ref    = is_indirect &&
                           (bank_ofs == OFS_INDIRECT_ACCESS_PORT);

  // Classify an in-bank offset into its storage target
  function automatic bmam_target_type decode(input logic [6:0] ofs);
    bmam_target_type t;
    t = BMAM_T_NONE;
    if (ofs <= SFR_LAST) begin
      if (ofs == OFS_PROGRAM_COUNTER_LOW) begin
        t = BMAM_T_PC_LOW;
      end else if (ofs == OFS_CORE_FLAGS_BANK) begin
        t = BMAM_T_FLAGS;
      end else if (ofs == OFS_INDIRECT_POINTER) begin
        t = BMAM_T_POINTER;
      end else if (ofs == OFS_PROGRAM_COUNTER_HIGH_LATCH) begin
        t = BMAM_T_LATCH;
      end else begin
        t = BMAM_T_NONE;
      end
    end else if (ofs >= GPR_FIRST && ofs <= GPR_LAST) begin
      t = BMAM_T_GPR;
    end else begin
      t = BMAM_T_NONE;
    end
    return t;
  endfunction

  // Target of the present access
  wire bmam_target_type target = self_ref ? BMAM_T_NONE
                                          : decode(bank_ofs);

  // Strobes per target; anything unmapped gets no write
  wire wr_pc_low  = bus.wr && (target == BMAM_T_PC_LOW);
  wire wr_flags   = bus.wr && (target == BMAM_T_FLAGS);
  wire wr_pointer = bus.wr && (target == BMAM_T_POINTER);
  wire wr_latch   = bus.wr && (target == BMAM_T_LATCH);
  wire wr_gpr     = bus.wr && (target == BMAM_T_GPR);

  // Same RAM byte regardless of bank
  wire [GPR_AW-1:0] gpr_index = GPR_AW'(bank_ofs - GPR_FIRST);

  // ****************************************************************
  // General purpose RAM
  // ****************************************************************
  logic [DATA_WIDTH-1:0] gpr_rdata;

  bmam_gpr_ram u_gpr (
    .clk_sys (clk_sys),
    .we      (wr_gpr),
    .waddr   (gpr_index),
    .wdata   (bus.wdata),
    .raddr   (gpr_index),
    .rdata   (gpr_rdata)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Read mux; unimplemented targets read zero
  always_comb begin
    case (target)
      BMAM_T_PC_LOW:  next_rdata = pc[7:0];
      BMAM_T_FLAGS:   next_rdata = flags;
      BMAM_T_POINTER: next_rdata = pointer;
      BMAM_T_LATCH:   next_rdata = {3'h0, latch};
      BMAM_T_GPR:     next_rdata = gpr_rdata;
      default:        next_rdata = 8'h00;
    endcase
  end

  // Read data registered, valid only the cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= RST_RDATA;
    end else if (bus.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= RST_RDATA;
    end
  end

  // ****************************************************************
  // Core registers
  // ****************************************************************

  // Flags: bits 4:3 hold their reset value of one, with no input to set them, and stay fixed.
  // Bits 7:6 are stored as written; software keeps them clear.
  assign next_flags = (flags & ~FLAGS_WR_MASK) |
                      (bus.wdata & FLAGS_WR_MASK);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags <= RST_FLAGS;
    end else if (wr_flags) begin
      flags <= next_flags;
    end
  end

  // Pointer holds a full eight-bit data address
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pointer <= RST_POINTER;
    end else if (wr_pointer) begin
      pointer <= bus.wdata;
    end
  end

  // Upper program counter latch, five bits
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latch <= RST_LATCH;
    end else if (wr_latch) begin
      latch <= bus.wdata[LATCH_WIDTH-1:0];
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************

  // Interrupt beats a counter write, which beats jump and step
  always_comb begin
    if (pc_ctl.irq) begin
      next_pc = IRQ_VECTOR;
    end else if (wr_pc_low) begin
      next_pc = {latch, bus.wdata};
    end else if (pc_ctl.jump) begin
      next_pc = pc_ctl.target;
    end else if (pc_ctl.step) begin
      next_pc = PC_WIDTH'(pc + 13'h0001);
    end else begin
      next_pc = pc;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc <= RESET_VECTOR;
    end else begin
      pc <= next_pc;
    end
  end

  // Only ten bits reach program memory, so high words alias low ones
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fetch_addr <= RESET_VECTOR[PROG_WIDTH-1:0];
    end else begin
      fetch_addr <= next_pc[PROG_WIDTH-1:0];
    end
  end

  // ****************************************************************
  // Observation outputs
  // ****************************************************************

  // Bank bit and resolved address of last access, for the core
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bank_sel  <= 1'b0;
      data_addr <= 8'h00;
    end else begin
      bank_sel <= wr_flags ? next_flags[BIT_BANK_SELECT]
                           : flags[BIT_BANK_SELECT];
      if (bus.wr || bus.rd) begin
        data_addr <= full_addr;
      end
    end
  end

endmodule

// [verilog/bmam_pkg.sv]
// Constants and types for the banked memory address map
package bmam_pkg;

  // ****************************************************************
  // Program side
  // ****************************************************************
  localparam int          PC_WIDTH      = 13;       // Full counter
  localparam int          PROG_WIDTH    = 10;       // Decoded fetch bits
  localparam int          PROG_WORD     = 14;       // Instruction width
  localparam logic [12:0] RESET_VECTOR  = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR    = 13'h0004;
  localparam int          LATCH_WIDTH   = 5;        // Upper pc bits held

  // ****************************************************************
  // Data side
  // ****************************************************************
  localparam int          FILE_WIDTH    = 7;        // Address in opcode
  localparam int          DATA_WIDTH    = 8;
  localparam int          GPR_DEPTH     = 64;
  localparam int          GPR_AW        = 6;
  localparam logic [6:0]  SFR_LAST      = 7'h1F;    // 32 special slots
  localparam logic [6:0]  GPR_FIRST     = 7'h20;
  localparam logic [6:0]  GPR_LAST      = 7'h5F;

  // Register offsets within a bank
  localparam logic [6:0]  OFS_INDIRECT_ACCESS_PORT = 7'h00;
  localparam logic [6:0]  OFS_PROGRAM_COUNTER_LOW  = 7'h02;
  localparam logic [6:0]  OFS_CORE_FLAGS_BANK      = 7'h03;
  localparam logic [6:0]  OFS_INDIRECT_POINTER     = 7'h04;
  localparam logic [6:0]  OFS_PROGRAM_COUNTER_HIGH_LATCH = 7'h0A;

  // Flag register field positions
  localparam int          BIT_BANK_SELECT     = 5;
  localparam int          BIT_RESERVED_BANK_B = 6;
  localparam int          BIT_RESERVED_BANK_A = 7;
  localparam logic [7:0]  FLAGS_WR_MASK       = 8'hE7; // Bits 4:3 fixed

  // Values after reset
  localparam logic [7:0]  RST_FLAGS    = 8'h18;
  localparam logic [7:0]  RST_POINTER  = 8'h00;
  localparam logic [4:0]  RST_LATCH    = 5'h00;
  localparam logic [7:0]  RST_RDATA    = 8'h00;

  // Register access from the core
  typedef struct packed {
    logic [6:0] addr;   // File address from the instruction
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bmam_bus_type;

  // Program counter control from the core
  typedef struct packed {
    logic        step;    // Advance to next word
    logic        jump;    // Load jump target
    logic [12:0] target;
    logic        irq;     // Interrupt taken
  } bmam_pc_ctl_type;

  // Decoded target of a data access
  typedef enum logic [2:0] {
    BMAM_T_NONE    = 3'b000,
    BMAM_T_PC_LOW  = 3'b001,
    BMAM_T_FLAGS   = 3'b010,
    BMAM_T_POINTER = 3'b011,
    BMAM_T_LATCH   = 3'b100,
    BMAM_T_GPR     = 3'b101
  } bmam_target_type;

endpackage

// [verilog/bmam_gpr_ram.sv]
// General purpose register storage, 64 bytes
`timescale 1ns/100ps
module bmam_gpr_ram
  import bmam_pkg::*;
(
  input  wire logic                  clk_sys, // System clock
  input  wire logic                  we,      // Write enable
  input  wire logic [GPR_AW-1:0]     waddr,   // Write index
  input  wire logic [DATA_WIDTH-1:0] wdata,   // Write byte
  input  wire logic [GPR_AW-1:0]     raddr,   // Read index
  output logic      [DATA_WIDTH-1:0] rdata    // Read byte, no latency
);

  logic [DATA_WIDTH-1:0] mem [GPR_DEPTH];

  // Storage is not reset, like static RAM
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule

// [test/bmam_map_chk.sv]
// Port assertions for the banked memory address map
`timescale 1ns/100ps
module bmam_map_chk
  import bmam_pkg::*;
(
  input wire logic                  clk_sys,    // Clock
  input wire logic                  arst_n,     // Reset, active low
  input wire bmam_bus_type          bus,        // Operand access
  input wire bmam_pc_ctl_type       pc_ctl,     // Counter control
  input wire logic [DATA_WIDTH-1:0] rdata,      // Read data
  input wire logic [PC_WIDTH-1:0]   pc,         // Program counter
  input wire logic [PROG_WIDTH-1:0] fetch_addr, // Fetch address
  input wire logic                  bank_sel,   // Bank select
  input wire logic [7:0]            data_addr   // Resolved address
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Decoded strobes and the low counter byte
  wire       acc    = bus.wr | bus.rd;
  // A write through the indirect slot may reach the counter as well
  wire       pc_wr  = bus.wr && (bus.addr == OFS_PROGRAM_COUNTER_LOW ||
                                 bus.addr == OFS_INDIRECT_ACCESS_PORT);
  wire [7:0] pc_lo  = pc[7:0];
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_fetch_wrap: assert property (fetch_addr == pc[9:0])
    else $error("fetch address not low ten counter bits");
  a_reset_vector: assert property ($rose(arst_n) |-> pc == 13'h0000)
    else $error("counter not at zero after reset");
  a_irq_vector: assert property (pc_ctl.irq |=> pc == IRQ_VECTOR)
    else $error("interrupt entry not loaded");
  a_step_wrap: assert property (pc_ctl.step && !pc_ctl.jump &&
    !pc_ctl.irq && !pc_wr |=> pc == $past(pc) + 13'h0001)
    else $error("counter step wrong");
  a_jump_load: assert property (pc_ctl.jump && !pc_ctl.irq &&
    !pc_wr |=> pc == $past(pc_ctl.target))
    else $error("jump target not loaded");
  a_bank_follow: assert property (bus.wr &&
    bus.addr == OFS_CORE_FLAGS_BANK |=> bank_sel == $past(bus.wdata[5]))
    else $error("bank select does not follow flag write");
  a_direct_addr: assert property (acc && bus.addr != 7'h00
    |=> data_addr == {$past(bank_sel), $past(bus.addr)})
    else $error("direct address wrong");
  a_unimpl_zero: assert property (bus.rd && bus.addr >= 7'h60
    |=> rdata == 8'h00)
    else $error("unimplemented read not zero");
  a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_pcl_read: assert property (bus.rd && bus.addr == 7'h02
    |=> rdata == $past(pc_lo))
    else $error("low counter byte read wrong");
  c_irq: cover property (pc_ctl.irq);
  c_indirect: cover property (bus.rd && bus.addr == 7'h00);
  c_bank1_wr: cover property (bus.wr && bank_sel);
endmodule
bind bmam_map bmam_map_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .bus(bus), .pc_ctl(pc_ctl), .rdata(rdata), .pc(pc),
  .fetch_addr(fetch_addr), .bank_sel(bank_sel), .data_addr(data_addr));

// [test/bmam_core_model.sv]
// Core model driving program counter control pulses
`timescale 1ns/100ps
module bmam_core_model
  import bmam_pkg::*;
(
  input  wire logic      clk_sys, // System clock
  output bmam_pc_ctl_type pc_ctl  // Counter control
);
  initial pc_ctl = '0;
  // One pulse of one cycle, launched after an edge
  task automatic issue(input logic st, input logic jp,
                       input logic [12:0] t, input logic iq);
    @(posedge clk_sys) pc_ctl <= '{st, jp, t, iq};
    @(posedge clk_sys) pc_ctl <= '0;
  endtask
endmodule

// [test/banked_memory_address_map_tb.sv]
// Self-checking bench for the banked memory address map
`timescale 1ns/100ps
`define CHK(g,e,n) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module banked_memory_address_map_tb;
  import bmam_pkg::*;
  logic clk_sys = 0;
  logic arst_n = 0;
  bmam_bus_type bus = '0;
  bmam_pc_ctl_type pc_ctl;
  logic [7:0] rdata, data_addr;
  logic [12:0] pc;
  logic [9:0] fetch_addr;
  logic bank_sel;
  int err_count = 0;
  int n_checks = 0;
  always #10 clk_sys = ~clk_sys;
  bmam_core_model core (.clk_sys(clk_sys), .pc_ctl(pc_ctl));
  bmam_map dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus),
    .pc_ctl(pc_ctl), .rdata(rdata), .pc(pc), .fetch_addr(fetch_addr),
    .bank_sel(bank_sel), .data_addr(data_addr));
  // Register bus cycles
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys) bus <= '0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_sys) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys) bus <= '0;
    #1 `CHK(rdata, e, "rdata")
  endtask
  // Counter pulse then settled check
  task automatic pcop(input logic st, jp, input logic [12:0] t,
                      input logic iq, input logic [12:0] e);
    core.issue(st, jp, t, iq);
    #1 `CHK(pc, e, "pc")
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #(20 * 5000);
    err_count++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1 `CHK(pc, 13'h0000, "pc")
    rd(7'h03, RST_FLAGS);
    rd(7'h04, 8'h00);
    $display("test reset done");
    wr(7'h20, 8'h11);
    wr(7'h5F, 8'h22);
    wr(7'h03, 8'h3F);
    #1 `CHK(bank_sel, 1'b1, "bank_sel")
    rd(7'h03, 8'h3F);
    rd(7'h20, 8'h11);
    rd(7'h5F, 8'h22);
    `CHK(data_addr, 8'hDF, "data_addr")
    wr(7'h60, 8'h55);
    rd(7'h20, 8'h11);
    rd(7'h60, 8'h00);
    rd(7'h7F, 8'h00);
    rd(7'h05, 8'h00);
    $display("test banks done");
    for (int i = 0; i < 64; i++) wr(7'h20 + i[6:0], 8'h40 + i[7:0]);
    for (int i = 0; i < 64; i++) begin
      wr(7'h04, 8'hA0 + i[7:0]);
      rd(7'h00, 8'h40 + i[7:0]);
    end
    `CHK(data_addr, 8'hDF, "data_addr")
    wr(7'h00, 8'h77);
    rd(7'h5F, 8'h77);
    wr(7'h04, 8'h80);
    wr(7'h00, 8'h99);
    rd(7'h00, 8'h00);
    wr(7'h03, 8'h00);
    #1 `CHK(bank_sel, 1'b0, "bank_sel")
    $display("test indirect done");
    pcop(1'b0, 1'b1, 13'h1FFF, 1'b0, 13'h1FFF);
    pcop(1'b1, 1'b0, 13'h0000, 1'b0, 13'h0000);
    pcop(1'b0, 1'b1, 13'h1404, 1'b0, 13'h1404);
    `CHK(fetch_addr, 10'h004, "fetch_addr")
    pcop(1'b1, 1'b1, 13'h0100, 1'b1, IRQ_VECTOR);
    wr(7'h0A, 8'hF5);
    rd(7'h0A, 8'h15);
    wr(7'h02, 8'h34);
    #1 `CHK(pc, 13'h1534, "pc")
    rd(7'h02, 8'h34);
    $display("test counter done");
    close_out();
  end
endmodule
